// ---- rtl/wdg_watchdog_timer.sv ----
/*
  Watchdog timer: a 24-bit retriggerable down-counter clocked by a
  10 kHz oscillator tick derived from the system clock, with a classic
  Wishbone register slave, sticky event status and a level interrupt.
  Assumes a 200 MHz clock, a synchronous stop_mode level from the power
  controller, and a reset controller that acts on chip_reset_req.
*/
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps

// Contract
// - Retriggerable one-shot; terminal count resets chip or interrupts.
// - Counter steps on a dedicated 10 kHz oscillator, not the bus clock; here the tick is divided down from clk.
// - Only off and on; once on it counts until refresh or expiry.
// - Refresh command or always-on option bit turns the watchdog on.
// - 24-bit down-counter reloads from upper, high and low reload bytes.
// - Nominal time-out in ms equals reload value divided by 10.
// - Refresh ignored once the count has reached 000002H.
// - Reset-on-timeout option picks chip reset or interrupt on expiry.
// - In stop mode expiry starts stop-mode recovery, not a system reset.
// - Oscillator signal is an alternate output function on a port pin.
module wdg_watchdog_timer #(
  parameter int OSC_DIV = wdg_pkg::OSC_DIV_CYC
) (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ce,
  input  wire logic                        wb_cyc,
  input  wire logic                        wb_stb,
  input  wire logic                        wb_we,
  input  wire logic [wdg_pkg::ADDR_W-1:0]  wb_adr,
  input  wire logic [wdg_pkg::SEL_W-1:0]   wb_sel,
  input  wire logic [wdg_pkg::DATA_W-1:0]  wb_dat_w,
  output logic      [wdg_pkg::DATA_W-1:0]  wb_dat_r,
  output logic                             wb_ack,
  input  wire logic                        stop_mode,
  output logic                             chip_reset_req,
  output logic                             stop_recovery,
  output logic                             irq,
  output logic                             rc_osc_out_pin,
  output logic                             rc_osc_out_oe
);
  import wdg_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(OSC_DIV / 2 - 1);

  logic                ack_q;
  logic [DATA_W-1:0]   dat_q;
  logic [CTRL_W-1:0]   ctrl_q;
  logic [BYTE_W-1:0]   rld_u_q;
  logic [BYTE_W-1:0]   rld_h_q;
  logic [BYTE_W-1:0]   rld_l_q;
  logic [ST_W-1:0]     st_q;
  logic [ST_W-1:0]     st_d;
  logic [ST_W-1:0]     en_q;
  logic [DIV_W-1:0]    div_q;
  logic [DIV_W-1:0]    div_d;
  logic                rc_q;
  logic                on_q;
  logic [CNT_W-1:0]    cnt_q;
  logic [CNT_W-1:0]    cnt_d;
  logic                rst_req_q;
  logic                stop_rec_q;

  wire                 req;
  wire                 wr_commit;
  wire                 hit_ctrl;
  wire                 hit_refresh;
  wire                 hit_rld_u;
  wire                 hit_rld_h;
  wire                 hit_rld_l;
  wire                 hit_count;
  wire                 hit_status;
  wire                 hit_clear;
  wire                 hit_irq_en;
  wire [DATA_W-1:0]    rdata;
  wire [CNT_W-1:0]     reload;
  wire                 opt_ao;
  wire                 opt_res;
  wire                 tick;
  wire                 refresh_req;
  wire                 refresh_ok;
  wire                 on_d;
  wire                 expire;
  wire [ST_W-1:0]      st_set;
  wire [ST_W-1:0]      st_clr;

  // ----------------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------------
  // A write takes effect on the edge that ends the ack cycle, one edge after ack rises.
  assign req         = wb_cyc & wb_stb;
  assign wr_commit   = ce & req & wb_we & ack_q & wb_sel[SEL_LOW_BIT];
  assign hit_ctrl    = (wb_adr == OFS_CTRL);
  assign hit_refresh = (wb_adr == OFS_REFRESH);
  assign hit_rld_u   = (wb_adr == OFS_RLD_U);
  assign hit_rld_h   = (wb_adr == OFS_RLD_H);
  assign hit_rld_l   = (wb_adr == OFS_RLD_L);
  assign hit_count   = (wb_adr == OFS_COUNT);
  assign hit_status  = (wb_adr == OFS_STATUS);
  assign hit_clear   = (wb_adr == OFS_CLEAR);
  assign hit_irq_en  = (wb_adr == OFS_IRQ_EN);

  // Unmapped and write-only addresses read as zero.
  assign rdata =
    hit_ctrl   ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q}  :
    hit_rld_u  ? {{(DATA_W-BYTE_W){1'b0}}, rld_u_q} :
    hit_rld_h  ? {{(DATA_W-BYTE_W){1'b0}}, rld_h_q} :
    hit_rld_l  ? {{(DATA_W-BYTE_W){1'b0}}, rld_l_q} :
    hit_count  ? {{(DATA_W-CNT_W){1'b0}}, cnt_q}    :
    hit_status ? {{(DATA_W-ST_W){1'b0}}, st_q}      :
    hit_irq_en ? {{(DATA_W-ST_W){1'b0}}, en_q}      :
    DATA_ZERO;

  assign wb_ack   = ack_q;
  assign wb_dat_r = dat_q;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_q <= 1'b0;
      dat_q <= DATA_ZERO;
    end
    else if (ce)
    begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q)
      begin
        dat_q <= rdata;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl_q  <= CTRL_RST;
      rld_u_q <= RLD_RST;
      rld_h_q <= RLD_RST;
      rld_l_q <= RLD_RST;
      en_q    <= ST_RST;
    end
    else if (wr_commit)
    begin
      if (hit_ctrl)   ctrl_q  <= wb_dat_w[CTRL_W-1:0];
      if (hit_rld_u)  rld_u_q <= wb_dat_w[BYTE_W-1:0];
      if (hit_rld_h)  rld_h_q <= wb_dat_w[BYTE_W-1:0];
      if (hit_rld_l)  rld_l_q <= wb_dat_w[BYTE_W-1:0];
      if (hit_irq_en) en_q    <= wb_dat_w[ST_W-1:0];
    end
  end

  assign reload  = {rld_u_q, rld_h_q, rld_l_q};
  assign opt_ao  = ctrl_q[CTRL_AO_BIT];
  assign opt_res = ctrl_q[CTRL_RES_BIT];

  // ----------------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------------
  // One tick per oscillator period; the square wave toggles twice per period.
  assign tick  = ce & (div_q == DIV_LAST);
  assign div_d = (div_q == DIV_LAST) ? DIV_ZERO : div_q + DIV_STEP;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q <= DIV_ZERO;
      rc_q  <= 1'b0;
    end
    else if (ce)
    begin
      div_q <= div_d;
      if ((div_q == DIV_LAST) || (div_q == DIV_HALF))
      begin
        rc_q <= ~rc_q;
      end
    end
  end

  assign rc_osc_out_pin = rc_q;
  assign rc_osc_out_oe  = ctrl_q[CTRL_OE_BIT];

  // ----------------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------------
  // Refreshes at or below the late limit are dropped so expiry is certain.
  assign refresh_req = wr_commit & hit_refresh;
  assign refresh_ok  = refresh_req & (~on_q | (cnt_q > LATE_CNT));
  assign on_d        = on_q | opt_ao | refresh_req;
  assign expire      = on_q & tick & (cnt_q <= TERM_CNT);

  // While off the counter tracks the reload value, so turning on loads it.
  always_comb
  begin
    if (~on_q)
      cnt_d = reload;
    else if (refresh_ok)
      cnt_d = reload;
    else if (expire)
      cnt_d = reload;
    else if (tick)
      cnt_d = cnt_q - CNT_STEP;
    else
      cnt_d = cnt_q;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      on_q  <= 1'b0;
      cnt_q <= CNT_RST;
    end
    else if (ce)
    begin
      on_q  <= on_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Expiry response and interrupt
  // ----------------------------------------------------------------------
  assign st_set[ST_TIMEOUT_BIT] = expire & ~stop_mode & ~opt_res;
  assign st_set[ST_STOPREC_BIT] = expire & stop_mode;
  assign st_clr = (wr_commit & hit_clear) ? wb_dat_w[ST_W-1:0] : ST_RST;
  // A new event outranks a clear written in the same cycle.
  assign st_d   = (st_q & ~st_clr) | st_set;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q       <= ST_RST;
      rst_req_q  <= 1'b0;
      stop_rec_q <= 1'b0;
    end
    else if (ce)
    begin
      st_q       <= st_d;
      rst_req_q  <= expire & ~stop_mode & opt_res;
      stop_rec_q <= expire & stop_mode;
    end
  end

  assign chip_reset_req = rst_req_q;
  assign stop_recovery  = stop_rec_q;
  assign irq            = |(st_q & en_q);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  expire_response_a: assert property (
    expire |=> (chip_reset_req | stop_recovery | st_q[ST_TIMEOUT_BIT]))
    else $error("Expiry produced no response.");

  tick_spacing_a: assert property (
    tick |=> !tick [*2])
    else $error("Oscillator ticks arrived too close together.");

  stays_on_a: assert property (
    on_q |=> on_q)
    else $error("Watchdog turned off after being on.");

  always_on_a: assert property (
    (ce && opt_ao) |=> on_q)
    else $error("Always-on option did not enable the watchdog.");

  refresh_reload_a: assert property (
    (refresh_ok && on_q) |=> (cnt_q == $past(reload)))
    else $error("Accepted refresh did not reload the counter.");

  count_step_a: assert property (
    (on_q && tick && (cnt_q > TERM_CNT) && !refresh_ok)
      |=> (cnt_q == $past(cnt_q) - CNT_STEP))
    else $error("Counter did not step down by one per tick.");

  late_refresh_a: assert property (
    (on_q && refresh_req && !tick && (cnt_q <= LATE_CNT))
      |=> (cnt_q == $past(cnt_q)))
    else $error("Late refresh was not ignored.");

  reset_select_a: assert property (
    (expire && !stop_mode)
      |=> (chip_reset_req == $past(opt_res))
          && (st_q[ST_TIMEOUT_BIT] || $past(opt_res)))
    else $error("Time-out response did not follow the reset option.");

  stop_recover_a: assert property (
    (expire && stop_mode) |=> (stop_recovery && !chip_reset_req))
    else $error("Stop-mode expiry did not start recovery alone.");

  reload_source_a: assert property (
    !on_q |=> (!on_q -> (cnt_q == $past(reload))))
    else $error("Idle counter does not hold the reload value.");

  ack_single_a: assert property (
    wb_ack |=> !wb_ack)
    else $error("Bus acknowledge lasted more than one cycle.");

  ack_answer_a: assert property (
    (ce && wb_cyc && wb_stb && !wb_ack) |=> wb_ack)
    else $error("Bus request was not acknowledged in one cycle.");

  reset_pulse_a: assert property (
    chip_reset_req |=> !chip_reset_req)
    else $error("Reset request lasted more than one cycle.");

  recover_pulse_a: assert property (
    stop_recovery |=> !stop_recovery)
    else $error("Stop-mode recovery lasted more than one cycle.");

  status_sticky_a: assert property (
    (st_q[ST_TIMEOUT_BIT] && !(wr_commit && hit_clear))
      |=> st_q[ST_TIMEOUT_BIT])
    else $error("Time-out status bit fell without a clear.");

  stop_no_timeout_a: assert property (
    (expire && stop_mode && !st_q[ST_TIMEOUT_BIT])
      |=> !st_q[ST_TIMEOUT_BIT])
    else $error("Stop-mode expiry raised the time-out status.");

  expire_reset_c: cover property (expire && opt_res && !stop_mode);
  expire_irq_c:   cover property (expire && !opt_res && irq);
  expire_stop_c:  cover property (expire && stop_mode);
  late_drop_c:    cover property (refresh_req && on_q && !refresh_ok);

endmodule : wdg_watchdog_timer

// ---- inc/wdg_pkg.sv ----
/*
  Holds the constants of the watchdog timer: register offsets, field
  positions, reset values, widths and the oscillator timing figures.
  Assumes a 200 MHz system clock and a 32-bit classic Wishbone bus.
*/
package wdg_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 4;
  localparam int CNT_W  = 24;
  localparam int BYTE_W = 8;
  localparam int DIV_W  = 15;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int RC_FREQ_KHZ  = 10;
  localparam int OSC_DIV_CYC  = CLK_FREQ_KHZ / RC_FREQ_KHZ;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_REFRESH = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_RLD_U   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_RLD_H   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_RLD_L   = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_CLEAR   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN  = 8'h20;

  // ----------------------------------------------------------------------
  // Fields
  // ----------------------------------------------------------------------
  localparam int CTRL_W         = 3;
  localparam int CTRL_AO_BIT    = 0;
  localparam int CTRL_RES_BIT   = 1;
  localparam int CTRL_OE_BIT    = 2;
  localparam int ST_W           = 2;
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_STOPREC_BIT = 1;
  localparam int SEL_LOW_BIT    = 0;

  // ----------------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST  = 3'h0;
  localparam logic [ST_W-1:0]   ST_RST    = 2'h0;
  localparam logic [BYTE_W-1:0] RLD_RST   = 8'hFF;
  localparam logic [CNT_W-1:0]  CNT_RST   = 24'hFF_FFFF;
  localparam logic [CNT_W-1:0]  TERM_CNT  = 24'h00_0001;
  localparam logic [CNT_W-1:0]  LATE_CNT  = 24'h00_0002;
  localparam logic [CNT_W-1:0]  RLD_MIN   = 24'h00_0004;
  localparam logic [CNT_W-1:0]  CNT_STEP  = 24'h00_0001;
  localparam logic [DIV_W-1:0]  DIV_ZERO  = 15'h0000;
  localparam logic [DIV_W-1:0]  DIV_STEP  = 15'h0001;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

endpackage : wdg_pkg

// ---- sim/wdg_watchdog_timer_test.sv ----
/*
  Self-checking bench for the watchdog timer: register table, refresh,
  expiry timing, the three expiry responses, interrupt mask and clear.
  Assumes the design package and runs the oscillator divider at 8.
*/
`timescale 1ns/1ps

module wdg_watchdog_timer_test;
  import wdg_pkg::*;

  localparam int DIV  = 8;
  localparam int NROW = 19;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [DATA_W-1:0] dat;
  } wdg_row_t;

  logic              clk, sys_rst, ce, wb_cyc, wb_stb, wb_we, wb_ack;
  logic              stop_mode, chip_reset_req, stop_recovery, irq;
  logic              rc_osc_out_pin, rc_osc_out_oe, prev;
  logic [ADDR_W-1:0] wb_adr;
  logic [SEL_W-1:0]  wb_sel;
  logic [DATA_W-1:0] wb_dat_w, wb_dat_r, q;
  int                n_fail = 0, n_checks = 0, cyc_n = 0;
  int                n_rst = 0, n_rec = 0, t0, k, j, tog;
  wdg_row_t          rows [NROW];

  wdg_watchdog_timer #(.OSC_DIV(DIV)) wdg_watchdog_timer_inst (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .ce             (ce),
    .wb_cyc         (wb_cyc),
    .wb_stb         (wb_stb),
    .wb_we          (wb_we),
    .wb_adr         (wb_adr),
    .wb_sel         (wb_sel),
    .wb_dat_w       (wb_dat_w),
    .wb_dat_r       (wb_dat_r),
    .wb_ack         (wb_ack),
    .stop_mode      (stop_mode),
    .chip_reset_req (chip_reset_req),
    .stop_recovery  (stop_recovery),
    .irq            (irq),
    .rc_osc_out_pin (rc_osc_out_pin),
    .rc_osc_out_oe  (rc_osc_out_oe)
  );

  // --------------------------------------------------------------------
  // Clock, monitors and tasks
  // --------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Counts the expiry pulses and cuts a hang short.
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (chip_reset_req === 1'b1)
      n_rst <= n_rst + 1;
    if (stop_recovery === 1'b1)
      n_rec <= n_rec + 1;
    if (cyc_n == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [DATA_W-1:0] s, input logic [DATA_W-1:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] d, input logic [SEL_W-1:0] s,
                    output logic [DATA_W-1:0] r);
    @(posedge clk);
    chk(32'(wb_ack), 32'h0000_0000);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_sel   <= s;
    wb_dat_w <= d;
    do
    begin
      @(posedge clk);
    end
    while (wb_ack !== 1'b1);
    r = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    wb(1'b1, a, d, 4'hF, r);
  endtask : wr

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] r;
    wb(1'b0, a, DATA_ZERO, 4'hF, r);
    chk(r, e);
  endtask : rdc

  task automatic wait_ev(input int lim);
    t0 = cyc_n;
    while (irq !== 1'b1 && cyc_n - t0 < lim)
      @(posedge clk);
  endtask : wait_ev

  // --------------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------------
  initial
  begin
    {sys_rst, ce, wb_cyc, wb_stb, wb_we, stop_mode} = 6'b11_0000;
    wb_adr = OFS_CTRL;
    wb_sel = 4'hF;
    wb_dat_w = DATA_ZERO;
    rows = '{'{1'b0, OFS_CTRL, 32'h0000_0000},
             '{1'b0, OFS_RLD_U, 32'h0000_00FF},
             '{1'b0, OFS_RLD_H, 32'h0000_00FF},
             '{1'b0, OFS_RLD_L, 32'h0000_00FF},
             '{1'b0, OFS_COUNT, 32'h00FF_FFFF},
             '{1'b0, OFS_STATUS, 32'h0000_0000},
             '{1'b0, OFS_IRQ_EN, 32'h0000_0000},
             '{1'b1, OFS_RLD_U, 32'h0000_0000},
             '{1'b1, OFS_RLD_H, 32'h0000_0000},
             '{1'b1, OFS_RLD_L, 32'h0000_0006},
             '{1'b0, OFS_RLD_L, 32'h0000_0006},
             '{1'b0, OFS_RLD_U, 32'h0000_0000},
             '{1'b1, 8'h24, 32'h0000_005A},
             '{1'b0, 8'h24, 32'h0000_0000},
             '{1'b1, OFS_CTRL, 32'h0000_0004},
             '{1'b0, OFS_CTRL, 32'h0000_0004},
             '{1'b1, OFS_IRQ_EN, 32'h0000_0003},
             '{1'b0, OFS_IRQ_EN, 32'h0000_0003},
             '{1'b0, OFS_COUNT, 32'h0000_0006}};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < NROW; i++)
    begin
      if (rows[i].we)
        wr(rows[i].adr, rows[i].dat);
      else
        rdc(rows[i].adr, rows[i].dat);
    end
    @(posedge clk);
    chk(32'(rc_osc_out_oe), 32'h0000_0001);
    tog = 0;
    prev = rc_osc_out_pin;
    repeat (8 * DIV)
    begin
      @(posedge clk);
      tog += int'(rc_osc_out_pin !== prev);
      prev = rc_osc_out_pin;
    end
    chk(32'(tog), 32'h0000_0010);
    wb(1'b1, OFS_RLD_L, 32'h0000_0009, 4'hE, q);
    rdc(OFS_RLD_L, 32'h0000_0006);
    wr(OFS_REFRESH, DATA_ZERO);
    k = cyc_n;
    wb(1'b0, OFS_COUNT, DATA_ZERO, 4'hF, q);
    chk(32'(q == 32'h0000_0006 || q == 32'h0000_0005), 32'h1);
    wait_ev(200);
    chk(32'(cyc_n - k >= 40 && cyc_n - k <= 52), 32'h1);
    chk(32'(n_rst), 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0001);
    wr(OFS_RLD_L, 32'h0000_0040);
    wr(OFS_REFRESH, DATA_ZERO);
    wb(1'b0, OFS_COUNT, DATA_ZERO, 4'hF, q);
    chk(32'(q == 32'h0000_0040 || q == 32'h0000_003F), 32'h1);
    wr(OFS_IRQ_EN, DATA_ZERO);
    @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_IRQ_EN, 32'h0000_0003);
    @(posedge clk);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_CLEAR, 32'h0000_0003);
    @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0000);
    // Refresh once the count has reached two: expiry must still follow.
    wr(OFS_RLD_L, 32'h0000_0006);
    wr(OFS_REFRESH, DATA_ZERO);
    j = 0;
    do
    begin
      wb(1'b0, OFS_COUNT, DATA_ZERO, 4'hF, q);
      j++;
    end
    while (q !== 32'h0000_0002 && j < 40);
    wr(OFS_REFRESH, DATA_ZERO);
    wait_ev(3 * DIV + 6);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0006);
    wr(OFS_CLEAR, 32'h0000_0003);
    k = n_rst;
    // One reload period of six ticks, with margin, holds exactly one expiry.
    repeat (6 * DIV + 12) @(posedge clk);
    chk(32'(n_rst - k), 32'h0000_0001);
    chk(32'(n_rec), 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0000);
    stop_mode <= 1'b1;
    k = n_rec;
    j = n_rst;
    wait_ev(100);
    // Lets the pulse counters take the recovery pulse first.
    @(posedge clk);
    chk(32'(n_rec - k), 32'h0000_0001);
    chk(32'(n_rst - j), 32'h0000_0000);
    rdc(OFS_STATUS, 32'h0000_0002);
    stop_mode <= 1'b0;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (5 * DIV) @(posedge clk);
    rdc(OFS_COUNT, 32'h00FF_FFFF);
    rdc(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (5 * DIV) @(posedge clk);
    wb(1'b0, OFS_COUNT, DATA_ZERO, 4'hF, q);
    chk(32'(q >= 32'h00FF_FFF9 && q <= 32'h00FF_FFFB), 32'h1);
    test_done();
  end

endmodule : wdg_watchdog_timer_test
